// ===== test/reed_pair_model.sv
// Purpose: Two reed switches over a magnetic rotor
// Assumes: Pull-ups, so both levels sit high at rest
// Notes: One rotor step per i_step pulse
`timescale 1ns/100ps
module reed_pair_model
  import reed_dir_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Step command
  input wire logic i_step,
  input wire logic i_back,
  // Switch levels
  output sensor_pair_t o_sensor
);
  logic [1:0] pos_ff;
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) pos_ff <= 2'h0;
    else if (i_step) pos_ff <= i_back ? pos_ff - 2'h1 : pos_ff + 2'h1;
  end
  // Quadrature walk 11,10,00,01 counts forward
  assign o_sensor = (pos_ff == 2'h0) ? 2'h3 : (pos_ff == 2'h1) ? 2'h2 : (pos_ff == 2'h2) ? 2'h0 : 2'h1;
endmodule

// ===== test/reed_rotation_direction_counter_tb_top.sv
// Purpose: Self-checking bench for the rotation counter
// Assumes: Partner model steps the rotor on command
// Notes: Expected counts follow the table rules
`timescale 1ns/100ps
module reed_rotation_direction_counter_tb_top;
  import reed_dir_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic step = 1'b0;
  logic back = 1'b0;
  int miscompares = 0;
  int total_checks = 0;
  logic [CNT_W-1:0] e_fwd;
  logic [CNT_W-1:0] e_bwd;
  logic e_arm;
  sensor_pair_t sens;
  count_bundle_t cnt;
  logic arm;
  logic evp;
  always #50 i_clk = ~i_clk;
  reed_pair_model reed_pair_model_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_step(step), .i_back(back),
    .o_sensor(sens));
  reed_rotation_direction_counter reed_rotation_direction_counter_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_sensor(sens), .o_counts(cnt), .o_armed_edge_flag(arm), .o_eval_pulse(evp));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [CNT_W-1:0] exp, input logic [CNT_W-1:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic check_all;
    chk("forward_count", e_fwd, cnt.forward_count);
    chk("backward_count", e_bwd, cnt.backward_count);
    chk("net_count", e_fwd - e_bwd, cnt.net_count);
    chk("armed_edge_flag", CNT_W'(e_arm), CNT_W'(arm));
  endtask
  task automatic do_reset;
    i_rst_b = 1'b0;
    e_fwd = '0;
    e_bwd = '0;
    e_arm = 1'b0;
    repeat (6) @(posedge i_clk);
    #1 i_rst_b = 1'b1;
    repeat (4) @(posedge i_clk);
    #1 check_all();
  endtask
  task automatic move(input logic dir);
    logic old_second;
    logic ev;
    logic [2:0] idx;
    int pulses;
    old_second = sens.second_sensor_level;
    step = 1'b1;
    back = dir;
    @(posedge i_clk);
    #1 step = 1'b0;
    idx = {e_arm, sens};
    ev = (sens.second_sensor_level != old_second) && (sens.second_sensor_level == e_arm);
    pulses = 0;
    repeat (6) begin
      @(posedge i_clk);
      #1 if (evp === 1'b1) pulses++;
    end
    if (ev) begin
      e_fwd += CNT_W'(idx == 3'h2 || idx == 3'h5);
      e_bwd += CNT_W'(idx == 3'h0 || idx == 3'h7);
      e_arm = ~idx[0];
    end
    chk("eval_pulse", CNT_W'(ev), CNT_W'(pulses));
    check_all();
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic fwd_run;
    logic [CNT_W-1:0] b;
    b = e_fwd;
    repeat (8) move(1'b0);
    chk("fwd_per_rev", b + CNT_W'(4), cnt.forward_count);
  endtask
  task automatic bwd_run;
    logic [CNT_W-1:0] b;
    b = e_bwd;
    repeat (8) move(1'b1);
    chk("bwd_per_rev", b + CNT_W'(4), cnt.backward_count);
  endtask
  task automatic vibrate;
    logic [CNT_W-1:0] n;
    n = e_fwd - e_bwd;
    repeat (6) begin
      move(1'b0);
      move(1'b1);
    end
    chk("vibration_net", n, cnt.net_count);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    do_reset();
    fwd_run();
    bwd_run();
    vibrate();
    do_reset();
    fwd_run();
    stop_test();
  end
endmodule

// ===== verilog/reed_dir_pkg.sv
// Purpose: Shared constants and types for the reed rotation direction counter
// Assumes: Two reed switch levels, one system clock
// Notes: Table contents are packed with index 0 in bit 0
package reed_dir_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int CNT_W = 32;
  localparam int IDX_W = 3;

  // ----------------------------------------
  // Lookup tables, bit n holds entry n
  // ----------------------------------------
  localparam logic [7:0] FORWARD_INC_TABLE = 8'h24;
  localparam logic [7:0] BACKWARD_INC_TABLE = 8'h81;
  localparam logic [7:0] NEXT_EDGE_TABLE = 8'h55;

  // ----------------------------------------
  // Armed edge encoding and reset values
  // ----------------------------------------
  localparam logic EDGE_RISING = 1'b1;
  localparam logic EDGE_FALLING = 1'b0;
  localparam logic ARMED_RST = EDGE_FALLING;
  localparam logic [CNT_W-1:0] CNT_RST = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 32'h0000_0001;
  localparam logic [1:0] SYNC_RST = 2'h0;
  localparam logic LEVEL_RST = 1'b0;

  // ----------------------------------------
  // Table indices that count, and revolution tracking
  // ----------------------------------------
  localparam logic [IDX_W-1:0] IDX_FWD_FALL = 3'h2;
  localparam logic [IDX_W-1:0] IDX_FWD_RISE = 3'h5;
  localparam logic [IDX_W-1:0] IDX_BWD_FALL = 3'h0;
  localparam logic [IDX_W-1:0] IDX_BWD_RISE = 3'h7;
  localparam int RUN_W = 3;
  localparam logic [RUN_W-1:0] RUN_RST = 3'h0;
  localparam logic [RUN_W-1:0] RUN_ONE = 3'h1;
  localparam logic [RUN_W-1:0] RUN_PER_REV = 3'h4;
  localparam logic [CNT_W-1:0] CNT_PER_REV = 32'h0000_0004;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic first_sensor_level;
    logic second_sensor_level;
  } sensor_pair_t;

  typedef struct packed {
    logic [CNT_W-1:0] forward_count;
    logic [CNT_W-1:0] backward_count;
    logic [CNT_W-1:0] net_count;
  } count_bundle_t;

  // Fetch one table entry
  function automatic logic table_bit(input logic [7:0] table_val, input logic [IDX_W-1:0] idx);
    table_bit = table_val[idx];
  endfunction

endpackage

// ===== verilog/reed_rotation_direction_counter.sv
// Purpose: Direction aware rotation counter from two quadrature reed switches
// Assumes: Inputs synchronous to i_clk at 10 MHz, debounced by the RC pull-ups
// Notes: Counts wrap at 2^32; net count is two's complement
`timescale 1ns/100ps

module reed_rotation_direction_counter
  import reed_dir_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // Reed switch levels
  input wire sensor_pair_t i_sensor,
  // Counts, armed edge flag and evaluation pulse
  output count_bundle_t o_counts,
  output logic o_armed_edge_flag,
  output logic o_eval_pulse
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  logic [1:0] first_sync_ff;
  logic [1:0] second_sync_ff;
  logic second_prev_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      first_sync_ff <= SYNC_RST;
      second_sync_ff <= SYNC_RST;
      second_prev_ff <= LEVEL_RST;
    end else begin
      first_sync_ff <= {first_sync_ff[0], i_sensor.first_sensor_level};
      second_sync_ff <= {second_sync_ff[0], i_sensor.second_sensor_level};
      second_prev_ff <= second_sync_ff[1];
    end
  end

  // ----------------------------------------
  // Edge detection and index
  // ----------------------------------------
  logic armed_edge_flag_ff;
  wire logic first_sensor_level = first_sync_ff[1];
  wire logic second_sensor_level = second_sync_ff[1];
  wire logic rise_seen = second_sensor_level & ~second_prev_ff;
  wire logic fall_seen = ~second_sensor_level & second_prev_ff;
  // Only second sensor edges trigger
  wire logic eval = (armed_edge_flag_ff == EDGE_RISING) ? rise_seen : fall_seen;
  wire logic [IDX_W-1:0] idx = {armed_edge_flag_ff, first_sensor_level, second_sensor_level};
  wire logic fwd_inc = table_bit(FORWARD_INC_TABLE, idx);
  wire logic bwd_inc = table_bit(BACKWARD_INC_TABLE, idx);
  wire logic nxt_armed = table_bit(NEXT_EDGE_TABLE, idx);

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  logic [CNT_W-1:0] forward_count_ff;
  logic [CNT_W-1:0] backward_count_ff;
  logic [CNT_W-1:0] net_count_ff;
  wire logic [CNT_W-1:0] nxt_forward = forward_count_ff + (fwd_inc ? CNT_ONE : CNT_RST);
  wire logic [CNT_W-1:0] nxt_backward = backward_count_ff + (bwd_inc ? CNT_ONE : CNT_RST);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      forward_count_ff <= CNT_RST;
      backward_count_ff <= CNT_RST;
      armed_edge_flag_ff <= ARMED_RST;
    end else if (eval) begin
      forward_count_ff <= nxt_forward;
      backward_count_ff <= nxt_backward;
      armed_edge_flag_ff <= nxt_armed;
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  logic eval_ff;
  logic armed_out_ff;

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      net_count_ff <= CNT_RST;
      eval_ff <= LEVEL_RST;
      armed_out_ff <= ARMED_RST;
    end else begin
      net_count_ff <= forward_count_ff - backward_count_ff;
      eval_ff <= eval;
      armed_out_ff <= armed_edge_flag_ff;
    end
  end

  assign o_counts.forward_count = forward_count_ff;
  assign o_counts.backward_count = backward_count_ff;
  assign o_counts.net_count = net_count_ff;
  assign o_armed_edge_flag = armed_out_ff;
  assign o_eval_pulse = eval_ff;

  // ----------------------------------------
  // Revolution tracking for the checks
  // ----------------------------------------
  function automatic logic run_restart(input logic [RUN_W-1:0] run);
    run_restart = (run == RUN_RST) || (run == RUN_PER_REV);
  endfunction

  function automatic logic [RUN_W-1:0] run_step(input logic [RUN_W-1:0] run, input logic ev, input logic hit);
    if (!ev) begin
      run_step = run;
    end else if (!hit) begin
      run_step = RUN_RST;
    end else if (run_restart(run)) begin
      run_step = RUN_ONE;
    end else begin
      run_step = run + RUN_ONE;
    end
  endfunction

  logic [RUN_W-1:0] fwd_run_ff;
  logic [RUN_W-1:0] bwd_run_ff;
  logic [CNT_W-1:0] fwd_run_base_ff;
  logic [CNT_W-1:0] fwd_run_other_ff;
  logic [CNT_W-1:0] bwd_run_base_ff;
  logic [CNT_W-1:0] bwd_run_other_ff;
  wire logic fwd_snap = eval & fwd_inc & run_restart(fwd_run_ff);
  wire logic bwd_snap = eval & bwd_inc & run_restart(bwd_run_ff);
  wire logic [RUN_W-1:0] nxt_fwd_run = run_step(fwd_run_ff, eval, fwd_inc);
  wire logic [RUN_W-1:0] nxt_bwd_run = run_step(bwd_run_ff, eval, bwd_inc);

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fwd_run_ff <= RUN_RST;
      bwd_run_ff <= RUN_RST;
    end else begin
      fwd_run_ff <= nxt_fwd_run;
      bwd_run_ff <= nxt_bwd_run;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fwd_run_base_ff <= CNT_RST;
      fwd_run_other_ff <= CNT_RST;
    end else if (fwd_snap) begin
      fwd_run_base_ff <= forward_count_ff;
      fwd_run_other_ff <= backward_count_ff;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bwd_run_base_ff <= CNT_RST;
      bwd_run_other_ff <= CNT_RST;
    end else if (bwd_snap) begin
      bwd_run_base_ff <= backward_count_ff;
      bwd_run_other_ff <= forward_count_ff;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);

  AST_HOLD_NO_EVAL: assert property (!eval |=> $stable(forward_count_ff) && $stable(backward_count_ff))
    else $error("Counters moved without evaluation");
  AST_FIRST_NO_TRIGGER: assert property (($changed(first_sync_ff[1]) && $stable(second_sync_ff[1])) |-> !eval)
    else $error("First sensor started evaluation");
  AST_FWD_IDX: assert property (eval && (idx == 3'h2 || idx == 3'h5) |=> forward_count_ff == $past(forward_count_ff) + CNT_ONE)
    else $error("Forward count missed");
  AST_BWD_IDX: assert property (eval && (idx == 3'h0 || idx == 3'h7) |=> backward_count_ff == $past(backward_count_ff) + CNT_ONE)
    else $error("Backward count missed");
  AST_NEXT_EDGE: assert property (eval |=> armed_edge_flag_ff == ~$past(second_sensor_level))
    else $error("Armed edge wrong");
  AST_RISE_ONLY: assert property (armed_edge_flag_ff && fall_seen |-> !eval)
    else $error("Falling edge taken while rising armed");
  AST_EXCLUSIVE: assert property (eval |=> !((forward_count_ff != $past(forward_count_ff)) && (backward_count_ff != $past(backward_count_ff))))
    else $error("Both counters incremented");
  AST_NET: assert property (##1 net_count_ff == $past(forward_count_ff) - $past(backward_count_ff))
    else $error("Net count mismatch");
  AST_PULSE: assert property (eval |=> o_eval_pulse ##1 (o_eval_pulse == $past(eval)))
    else $error("Evaluation pulse wrong");

  AST_RESET_VALUES: assert property (
    $rose(i_rst_b)
    |-> forward_count_ff == CNT_RST && backward_count_ff == CNT_RST && armed_edge_flag_ff == ARMED_RST)
    else $error("Reset values wrong");

  AST_FIRST_SYNC: assert property (
    $past(i_rst_b, 2)
    |-> first_sensor_level == $past(i_sensor.first_sensor_level, 2))
    else $error("First sensor synchroniser wrong");

  AST_SECOND_SYNC: assert property (
    $past(i_rst_b, 2)
    |-> second_sensor_level == $past(i_sensor.second_sensor_level, 2))
    else $error("Second sensor synchroniser wrong");

  AST_PREV_FOLLOWS: assert property (
    $past(i_rst_b)
    |-> second_prev_ff == $past(second_sensor_level))
    else $error("Second sensor history wrong");

  AST_IDX_FALL_HIGH: assert property (
    eval && armed_edge_flag_ff == EDGE_FALLING && first_sensor_level
    |=> forward_count_ff == $past(forward_count_ff) + CNT_ONE && $stable(backward_count_ff))
    else $error("Index order wrong on falling edge");

  AST_IDX_RISE_HIGH: assert property (
    eval && armed_edge_flag_ff == EDGE_RISING && first_sensor_level
    |=> backward_count_ff == $past(backward_count_ff) + CNT_ONE && $stable(forward_count_ff))
    else $error("Index order wrong on rising edge");

  AST_FWD_ZERO: assert property (
    eval && idx != IDX_FWD_FALL && idx != IDX_FWD_RISE
    |=> $stable(forward_count_ff))
    else $error("Forward count moved on zero entry");

  AST_BWD_ZERO: assert property (
    eval && idx != IDX_BWD_FALL && idx != IDX_BWD_RISE
    |=> $stable(backward_count_ff))
    else $error("Backward count moved on zero entry");

  AST_FWD_STEP: assert property (
    eval
    |=> forward_count_ff - $past(forward_count_ff) == (FORWARD_INC_TABLE[$past(idx)] ? CNT_ONE : CNT_RST))
    else $error("Forward step wrong");

  AST_BWD_STEP: assert property (
    eval
    |=> backward_count_ff - $past(backward_count_ff) == (BACKWARD_INC_TABLE[$past(idx)] ? CNT_ONE : CNT_RST))
    else $error("Backward step wrong");

  AST_FLAG_ALTERNATES: assert property (
    eval
    |=> armed_edge_flag_ff != $past(armed_edge_flag_ff))
    else $error("Armed edge did not alternate");

  AST_FLAG_HOLD: assert property (
    !eval
    |=> $stable(armed_edge_flag_ff))
    else $error("Armed edge moved without evaluation");

  AST_FALL_ONLY: assert property (
    armed_edge_flag_ff == EDGE_FALLING && rise_seen
    |-> !eval)
    else $error("Rising edge taken while falling armed");

  AST_RISE_TAKEN: assert property (
    armed_edge_flag_ff == EDGE_RISING && rise_seen
    |-> eval)
    else $error("Armed rising edge missed");

  AST_FALL_TAKEN: assert property (
    armed_edge_flag_ff == EDGE_FALLING && fall_seen
    |-> eval)
    else $error("Armed falling edge missed");

  AST_FWD_PATTERN: assert property (
    eval && first_sensor_level != second_sensor_level
    |=> forward_count_ff == $past(forward_count_ff) + CNT_ONE && $stable(backward_count_ff))
    else $error("Forward pattern not counted forward");

  AST_BWD_PATTERN: assert property (
    eval && first_sensor_level == second_sensor_level
    |=> backward_count_ff == $past(backward_count_ff) + CNT_ONE && $stable(forward_count_ff))
    else $error("Backward pattern not counted backward");

  AST_FWD_REV: assert property (
    fwd_run_ff == RUN_PER_REV
    |-> forward_count_ff - fwd_run_base_ff == CNT_PER_REV && backward_count_ff == fwd_run_other_ff)
    else $error("Forward revolution count wrong");

  AST_BWD_REV: assert property (
    bwd_run_ff == RUN_PER_REV
    |-> backward_count_ff - bwd_run_base_ff == CNT_PER_REV && forward_count_ff == bwd_run_other_ff)
    else $error("Backward revolution count wrong");

  AST_SINGLE_EVAL: assert property (
    eval
    |=> !eval)
    else $error("Evaluation repeated");

  AST_ARMED_OUT: assert property (
    $past(i_rst_b)
    |-> o_armed_edge_flag == $past(armed_edge_flag_ff))
    else $error("Armed edge output wrong");

  AST_PULSE_ONE: assert property (
    o_eval_pulse
    |=> !o_eval_pulse)
    else $error("Evaluation pulse too long");

  COV_FWD: cover property (eval && fwd_inc ##[1:50] eval && fwd_inc);
  COV_BWD: cover property (eval && bwd_inc ##[1:50] eval && bwd_inc);
  COV_VIB: cover property (eval && fwd_inc ##[1:50] eval && bwd_inc);
  COV_NO_COUNT: cover property (eval && !fwd_inc && !bwd_inc);
  COV_REV: cover property (fwd_run_ff == RUN_PER_REV);

endmodule
